// ### core/tws_ctrl.sv
// two-wire serial controller: apb registers, byte engine, master sequencer
// assumes open-drain pads outside; an external timer counts scl-low time
//
// Overview of operation
// RULE_01: serial bit never faster than clock/20
// RULE_02: host moves bytes, hardware moves bits
// RULE_03: start, address with direction, data, stop
// RULE_04: direction one reads, zero writes
// RULE_05: ack is sda low while scl high
// RULE_06: transmitter drives bits, receiver drives ack
// RULE_07: write and read byte flow, master stops
// RULE_08: master makes every scl pulse
// RULE_09: master starts only on a free bus
// RULE_10: arbitration loser releases, becomes slave; the code makes it slave only on a loss in the address byte
// RULE_11: master waits for scl really high
// RULE_12: scl low timeout handled by reset
// RULE_13: timer reloads while scl high
// RULE_14: instance picks timer three or four
// RULE_15: disable then enable resets communication
// RULE_16: bus free after ten idle periods
// RULE_17: pending start issued when bus frees
// RULE_18: free detection needs clock source running
// RULE_19: software or hardware address ack
// RULE_20: lines only pulled low, never driven high
// RULE_21: second instance behaves like the first
// RULE_22: two-bit select picks overflow source
// RULE_23: scl phases at least one period
// RULE_24: event flag on bytes, start, slave stop
// RULE_25: start and stop detect and generate
// RULE_26: arbitration loss flag for software
`timescale 1ns/1ns
module tws_ctrl import tws_pkg::*; (
	input wire logic i_core_clk, // core clock, 20 mhz
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb write
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	input wire logic [3:0] i_clk_ovf, // timer overflow pulses
	input wire logic i_scl, // scl pin level
	input wire logic i_sda, // sda pin level
	output logic o_scl_o, // scl output value, always low
	output logic o_scl_oe, // scl pulled low when high
	output logic o_sda_o, // sda output value, always low
	output logic o_sda_oe, // sda pulled low when high
	output logic o_tmr_reload // timeout timer reload level
);
	tws_mst_st_t st_q, st_d; // master sequencer
	logic [6:0] cfg_q; // bus_config_reg
	logic [6:0] own_q; // own slave address
	logic [7:0] data_q, sh_q; // data register, shifter
	logic [3:0] bcnt_q; // bit index, 8 is ack slot
	logic sta_q, sto_q, ack_q, si_q, arb_q; // control and status flags
	logic master_q, slv_q, addr_ph_q, tx_q, first_q, busy_q; // roles
	logic dat_sda_q; // engine wants sda low
	logic [1:0] ph_tk_q; // source periods in this phase
	logic [4:0] ph_cy_q; // core cycles in this phase
	logic [31:0] prdata_q, rd; // read data, register and mux
	logic pready_q, pslverr_q, hit; // apb answer
	logic scl_oe_q, sda_oe_q, reload_q; // pin drives
	logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det; // line events
	logic tick, free_pls, ph_done, apb_wr, wr_ctl, resume, arb_ev; // strobes
	logic m_scl, m_sda, ack_new; // helpers
	logic cfg_en, cfg_inh, cfg_toe, cfg_fte, cfg_hwack; // config fields

	assign cfg_en = cfg_q[CFG_EN];
	assign cfg_inh = cfg_q[CFG_INH];
	assign cfg_toe = cfg_q[CFG_TOE];
	assign cfg_fte = cfg_q[CFG_FTE];
	assign cfg_hwack = cfg_q[CFG_HWACK];

	// line sampling and start / stop detection
	tws_line_mon u_mon (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_scl(scl_q),
		.o_sda(sda_q),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(start_det),
		.o_stop(stop_det)
	);

	// bit-clock source and bus-free timer
	tws_bit_tick u_tick (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ovf(i_clk_ovf),
		.i_sel(cfg_q[CFG_CS+1:CFG_CS]),
		.i_free_en(cfg_fte & cfg_en),
		.i_idle(scl_q & sda_q),
		.o_tick(tick),
		.o_free(free_pls)
	);

	// apb decode, one wait-free access phase
	assign hit = (i_paddr == REG_CFG) || (i_paddr == REG_CTL) || (i_paddr == REG_DAT) || (i_paddr == REG_ADR);
	assign apb_wr = i_psel & i_penable & pready_q & i_pwrite & hit;
	assign wr_ctl = apb_wr && (i_paddr == REG_CTL);
	assign resume = wr_ctl & i_pwdata[CTL_SI] & si_q;
	assign ack_new = i_pwdata[CTL_ACK];

	// read mux, unused bits zero
	always_comb begin
		rd = 32'h0;
		if (i_paddr == REG_CFG) begin
			rd = {25'h0, cfg_q};
		end else if (i_paddr == REG_CTL) begin
			rd = {23'h0, slv_q, busy_q, arb_q, tx_q, master_q, si_q, ack_q, sto_q, sta_q};
		end else if (i_paddr == REG_DAT) begin
			rd = {24'h0, data_q};
		end else if (i_paddr == REG_ADR) begin
			rd = {24'h0, own_q, 1'b0};
		end
	end

	// apb answer registered in the setup cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= i_psel & ~i_penable;
			if (i_psel && !i_penable) begin
				prdata_q <= i_pwrite ? 32'h0 : rd;
				pslverr_q <= ~hit;
			end
		end
	end

	// configuration and own address; host access is whole bytes
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q <= CFG_RST;
			own_q <= ADR_RST;
		end else if (apb_wr && i_paddr == REG_CFG) begin
			cfg_q <= i_pwdata[6:0]; // RULE_02
		end else if (apb_wr && i_paddr == REG_ADR) begin
			own_q <= i_pwdata[7:1];
		end
	end

	// master sequencer next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			M_IDLE: begin
				if (cfg_en && sta_q && !busy_q) st_d = M_START_REL; // RULE_09 RULE_17
			end
			M_START_REL: begin
				if (scl_q && sda_q && ph_done) st_d = M_START_SDA;
			end
			M_START_SDA: begin
				if (ph_done) st_d = M_START_SCL; // RULE_25
			end
			M_START_SCL: begin
				if (ph_done) st_d = M_LOW;
			end
			M_LOW: begin
				if (!master_q) begin
					st_d = M_IDLE; // RULE_10
				end else if (!si_q && ph_done) begin
					if (bcnt_q == 4'h0 && sto_q) st_d = M_STOP_LO; // RULE_07
					else if (bcnt_q == 4'h0 && sta_q) st_d = M_START_REL;
					else st_d = M_HIGH; // RULE_08
				end
			end
			M_HIGH: begin
				if (!master_q) st_d = M_IDLE;
				else if (scl_q && ph_done) st_d = M_LOW; // RULE_11
			end
			M_STOP_LO: begin
				if (ph_done) st_d = M_STOP_HI;
			end
			M_STOP_HI: begin
				if (scl_q && ph_done) st_d = M_STOP_END;
			end
			M_STOP_END: begin
				if (ph_done) st_d = M_IDLE; // RULE_25
			end
			default: begin
				st_d = M_IDLE;
			end
		endcase
		if (!cfg_en) st_d = M_IDLE; // RULE_15
	end

	// sequencer state
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= M_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// phase timer; restarts on a new phase or while scl is held low in M_HIGH or M_STOP_HI
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_tk_q <= 2'h0;
			ph_cy_q <= 5'h0;
		end else if (st_d != st_q || (!scl_q && (st_q == M_HIGH || st_q == M_STOP_HI))) begin
			ph_tk_q <= 2'h0; // RULE_11
			ph_cy_q <= 5'h0;
		end else begin
			if (tick && ph_tk_q != 2'h3) ph_tk_q <= ph_tk_q + 2'h1;
			if (ph_cy_q != MIN_HALF) ph_cy_q <= ph_cy_q + 5'h1;
		end
	end
	// high takes two periods, low one; each at least ten cycles
	assign ph_done = (ph_tk_q >= ((st_q == M_HIGH) ? HIGH_TICKS : LOW_TICKS)) && (ph_cy_q == MIN_HALF); // RULE_23 RULE_01

	// losing master released high but saw low
	// only in a data bit high phase; the low sda of our own stop is no loss
	assign arb_ev = scl_rise & master_q & tx_q & (st_q == M_HIGH) & (bcnt_q != 4'h8) & ~dat_sda_q & ~sda_q;

	// byte engine and flags; later assignments (hardware) win over host
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sta_q <= 1'b0;
			sto_q <= 1'b0;
			ack_q <= 1'b0;
			si_q <= 1'b0;
			arb_q <= 1'b0;
			data_q <= 8'h00;
			sh_q <= 8'h00;
			bcnt_q <= 4'h0;
			master_q <= 1'b0;
			slv_q <= 1'b0;
			addr_ph_q <= 1'b0;
			tx_q <= 1'b0;
			first_q <= 1'b0;
			busy_q <= 1'b0;
			dat_sda_q <= 1'b0;
		end else begin
			// host writes
			if (wr_ctl) begin
				sta_q <= i_pwdata[CTL_STA];
				sto_q <= i_pwdata[CTL_STO];
				ack_q <= i_pwdata[CTL_ACK];
				if (i_pwdata[CTL_SI]) si_q <= 1'b0;
				if (i_pwdata[CTL_ARB]) arb_q <= 1'b0;
			end
			if (apb_wr && i_paddr == REG_DAT) data_q <= i_pwdata[7:0];
			// host released the held byte slot
			if (resume) begin
				if (tx_q && bcnt_q == 4'h0) begin
					sh_q <= data_q; // RULE_06
					dat_sda_q <= ~data_q[7] & (master_q | ack_q);
				end else if (bcnt_q == 4'h8 && !tx_q) begin
					dat_sda_q <= ack_new; // RULE_05 RULE_19
					if (addr_ph_q && ack_new) begin
						addr_ph_q <= 1'b0;
						tx_q <= sh_q[0]; // RULE_04
					end else if (addr_ph_q) begin
						slv_q <= 1'b0;
					end
				end
			end
			// bus state from line events
			if (start_det) begin
				busy_q <= 1'b1;
				if (st_q == M_IDLE && !cfg_inh) begin
					slv_q <= 1'b1; // RULE_03
					addr_ph_q <= 1'b1;
					tx_q <= 1'b0;
					bcnt_q <= 4'h0;
					dat_sda_q <= 1'b0;
				end
			end
			if (stop_det) begin
				busy_q <= 1'b0; // RULE_09
				if (slv_q && !addr_ph_q) si_q <= 1'b1; // RULE_24
				slv_q <= 1'b0;
				addr_ph_q <= 1'b0;
				dat_sda_q <= 1'b0;
			end
			if (free_pls && cfg_fte) busy_q <= 1'b0; // RULE_16
			// own start finished: flag it and wait for the address byte
			if (st_q == M_START_SCL && st_d == M_LOW) begin
				master_q <= 1'b1;
				tx_q <= 1'b1;
				first_q <= 1'b1;
				bcnt_q <= 4'h0;
				si_q <= 1'b1; // RULE_24
				sta_q <= 1'b0;
				dat_sda_q <= 1'b0;
			end
			if (st_q == M_STOP_END && st_d == M_IDLE) begin
				master_q <= 1'b0;
				sto_q <= 1'b0;
			end
			// sample on scl rise
			if (scl_rise && (master_q || slv_q)) begin
				if (bcnt_q != 4'h8) begin
					sh_q <= {sh_q[6:0], sda_q};
					if (arb_ev) begin
						arb_q <= 1'b1; // RULE_26
						master_q <= 1'b0; // RULE_10
						dat_sda_q <= 1'b0;
						if (first_q) begin
							slv_q <= ~cfg_inh;
							addr_ph_q <= 1'b1;
							tx_q <= 1'b0;
						end
					end
				end else if (tx_q) begin
					ack_q <= ~sda_q; // RULE_05
				end
			end
			// change sda on scl fall
			if (scl_fall && (master_q || slv_q)) begin
				if (bcnt_q < 4'h7) begin
					bcnt_q <= bcnt_q + 4'h1;
					dat_sda_q <= tx_q & ~sh_q[7]; // RULE_06 RULE_20
				end else if (bcnt_q == 4'h7) begin
					bcnt_q <= 4'h8;
					dat_sda_q <= 1'b0;
					if (!tx_q) begin
						data_q <= sh_q; // RULE_02
						if (addr_ph_q && cfg_hwack) begin
							if (sh_q[7:1] == own_q && !cfg_inh) begin
								dat_sda_q <= 1'b1; // RULE_19
								addr_ph_q <= 1'b0;
								tx_q <= sh_q[0]; // RULE_04
							end else begin
								slv_q <= 1'b0;
							end
						end else if (cfg_hwack) begin
							dat_sda_q <= ack_q;
						end else begin
							si_q <= 1'b1; // RULE_19
						end
					end
				end else begin
					bcnt_q <= 4'h0;
					dat_sda_q <= 1'b0;
					first_q <= 1'b0;
					if (master_q && first_q) tx_q <= ~sh_q[0]; // RULE_04 RULE_07
					if (tx_q || cfg_hwack) si_q <= 1'b1; // RULE_24
				end
			end
			// disable drops the bus state; tx_q and the host flags keep their values
			if (!cfg_en) begin
				master_q <= 1'b0; // RULE_15 RULE_12
				slv_q <= 1'b0;
				addr_ph_q <= 1'b0;
				bcnt_q <= 4'h0;
				dat_sda_q <= 1'b0;
				busy_q <= 1'b0;
				first_q <= 1'b0;
			end
		end
	end

	// who pulls which line low
	assign m_scl = (st_q == M_START_SCL) || (st_q == M_LOW) || (st_q == M_STOP_LO);
	assign m_sda = (st_q == M_START_SDA) || (st_q == M_START_SCL) || (st_q == M_STOP_LO) ||
		(st_q == M_STOP_HI) || (dat_sda_q && (st_q == M_LOW || st_q == M_HIGH));

	// open-drain pin drives and timer reload
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			reload_q <= 1'b0;
		end else begin
			scl_oe_q <= cfg_en & (m_scl | (slv_q & si_q)); // RULE_20 RULE_08
			sda_oe_q <= cfg_en & (m_sda | (slv_q & dat_sda_q)); // RULE_20
			reload_q <= cfg_en & cfg_toe & scl_q; // RULE_13 RULE_14 RULE_21
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_scl_oe = scl_oe_q;
	assign o_sda_oe = sda_oe_q;
	assign o_tmr_reload = reload_q;
	assign o_scl_o = 1'b0 & scl_oe_q;
	assign o_sda_o = 1'b0 & sda_oe_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_pend_free;
		st_q == M_IDLE && sta_q && cfg_en && cfg_fte && free_pls && !start_det && !stop_det;
	endsequence
	sequence s_start_out;
		##1 !busy_q ##1 st_q == M_START_REL;
	endsequence

	property p_low_min;
		(st_q == M_LOW && st_d == M_HIGH) |-> ph_cy_q == MIN_HALF && ph_tk_q >= LOW_TICKS;
	endproperty
	a_low_min: assert property (p_low_min) else $error("scl low phase too short"); // RULE_01
	property p_start_free;
		(st_q == M_IDLE && st_d == M_START_REL) |-> !busy_q;
	endproperty
	a_start_free: assert property (p_start_free) else $error("start on a busy bus"); // RULE_09
	property p_arb;
		arb_ev |=> arb_q && !master_q ##1 !m_scl;
	endproperty
	a_arb: assert property (p_arb) else $error("lost arbitration not released"); // RULE_10
	property p_stretch;
		(st_q == M_HIGH && !scl_q && master_q && cfg_en) |=> st_q == M_HIGH && ph_cy_q == 5'h0;
	endproperty
	a_stretch: assert property (p_stretch) else $error("master ran over stretched scl"); // RULE_11
	property p_reload;
		(cfg_en && cfg_toe && !scl_q)[*2] |-> !o_tmr_reload;
	endproperty
	a_reload: assert property (p_reload) else $error("timer reloaded while scl low"); // RULE_13
	property p_disable;
		!cfg_en |=> st_q == M_IDLE && !master_q && !slv_q ##1 !o_scl_oe && !o_sda_oe;
	endproperty
	a_disable: assert property (p_disable) else $error("disable left bus state"); // RULE_15
	property p_free_start;
		s_pend_free |-> s_start_out;
	endproperty
	a_free_start: assert property (p_free_start) else $error("pending start not issued"); // RULE_17
	property p_start_flag;
		(st_q == M_START_SCL && st_d == M_LOW) |=> si_q && master_q && tx_q;
	endproperty
	a_start_flag: assert property (p_start_flag) else $error("no event after start"); // RULE_24
	property p_slave_hold;
		(slv_q && si_q && cfg_en)[*2] |-> o_scl_oe;
	endproperty
	a_slave_hold: assert property (p_slave_hold) else $error("slave released scl while flagged"); // RULE_02
endmodule : tws_ctrl

// ### core/tws_pkg.sv
// two-wire serial controller: shared constants, register map and state type
// assumes a single 20 mhz core clock and an apb register port
package tws_pkg;
	// core clock and serial rate floor
	localparam int unsigned CLK_HZ = 20000000; // core clock rate
	localparam int unsigned SYS_PER_BIT = 20; // fastest bit is 1/20 of core clock
	localparam logic [4:0] MIN_HALF = 5'(SYS_PER_BIT / 2); // least cycles per scl phase
	// bit-clock source periods
	localparam logic [1:0] LOW_TICKS = 2'h1; // scl low phase in source periods
	localparam logic [1:0] HIGH_TICKS = 2'h2; // scl high phase in source periods
	localparam logic [3:0] FREE_TICKS = 4'ha; // idle periods before bus counts free
	// register byte offsets
	localparam logic [7:0] REG_CFG = 8'h00; // bus_config_reg
	localparam logic [7:0] REG_CTL = 8'h04; // control and status
	localparam logic [7:0] REG_DAT = 8'h08; // data byte
	localparam logic [7:0] REG_ADR = 8'h0c; // own slave address
	// bus_config_reg fields
	localparam int CFG_EN = 0; // controller enable
	localparam int CFG_INH = 1; // inhibit slave events
	localparam int CFG_TOE = 2; // scl_low_timeout_enable
	localparam int CFG_FTE = 3; // bus_free_timeout_enable
	localparam int CFG_CS = 4; // bit_clock_source_select, two bits
	localparam int CFG_HWACK = 6; // hardware address match and ack
	localparam logic [6:0] CFG_RST = 7'h00; // config after reset
	localparam logic [6:0] ADR_RST = 7'h00; // own address after reset
	// control and status fields
	localparam int CTL_STA = 0; // start request
	localparam int CTL_STO = 1; // stop request
	localparam int CTL_ACK = 2; // ack to send / ack seen
	localparam int CTL_SI = 3; // byte event flag, write 1 clears
	localparam int CTL_MST = 4; // acting as master
	localparam int CTL_TX = 5; // acting as transmitter
	localparam int CTL_ARB = 6; // arbitration lost, write 1 clears
	localparam int CTL_BUSY = 7; // bus busy
	localparam int CTL_SLV = 8; // addressed or in address phase
	// master sequencer states
	typedef enum logic [3:0] {
		M_IDLE, M_START_REL, M_START_SDA, M_START_SCL, M_LOW, M_HIGH,
		M_STOP_LO, M_STOP_HI, M_STOP_END
	} tws_mst_st_t;
endpackage : tws_pkg

// ### core/tws_line_mon.sv
// two-wire serial controller: line sampler and start / stop detector
// assumes scl and sda pin levels arrive synchronous to the core clock
`timescale 1ns/1ns
module tws_line_mon (
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_scl, // scl pin level
	input wire logic i_sda, // sda pin level
	output logic o_scl, // sampled scl
	output logic o_sda, // sampled sda
	output logic o_scl_rise, // scl rose, pulse
	output logic o_scl_fall, // scl fell, pulse
	output logic o_start, // start seen, pulse
	output logic o_stop // stop seen, pulse
);
	logic scl_q, sda_q, scl_p_q, sda_p_q; // current and previous samples

	// sample both lines, idle high after reset
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	assign o_scl = scl_q;
	assign o_sda = sda_q;
	assign o_scl_rise = scl_q & ~scl_p_q;
	assign o_scl_fall = ~scl_q & scl_p_q;
	// sda moving while scl stays high marks start or stop
	assign o_start = scl_q & scl_p_q & sda_p_q & ~sda_q; // RULE_25
	assign o_stop = scl_q & scl_p_q & ~sda_p_q & sda_q; // RULE_25
endmodule : tws_line_mon

// ### core/tws_bit_tick.sv
// two-wire serial controller: bit-clock source select and bus-free timer
// assumes the timer overflow inputs are one-cycle pulses on the core clock
`timescale 1ns/1ns
module tws_bit_tick import tws_pkg::*; (
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic [3:0] i_ovf, // timer overflow pulses
	input wire logic [1:0] i_sel, // bit_clock_source_select
	input wire logic i_free_en, // free timeout armed
	input wire logic i_idle, // scl and sda both high
	output logic o_tick, // selected overflow, pulse
	output logic o_free // bus went free, pulse
);
	logic tick_q; // registered selected overflow
	logic [3:0] cnt_q; // idle source periods seen

	// pick one overflow source
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= i_ovf[i_sel]; // RULE_22
		end
	end

	// count idle periods; needs the source running even as slave
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 4'h0;
		end else if (!i_free_en || !i_idle) begin
			cnt_q <= 4'h0;
		end else if (tick_q && cnt_q <= FREE_TICKS) begin
			cnt_q <= cnt_q + 4'h1; // RULE_18
		end
	end

	assign o_tick = tick_q;
	// fires on the period that takes the count past ten
	assign o_free = i_free_en & i_idle & tick_q & (cnt_q == FREE_TICKS); // RULE_16
endmodule : tws_bit_tick

// ### dv/tws_slave_model.sv
// bench partner: a slave receiver with a fixed 7-bit address on the two-wire bus
// assumes the bench resolves the wired-and levels and feeds them back here
`timescale 1ns/1ns
module tws_slave_model #(parameter logic [6:0] ADDR = 7'h52) (
	input wire logic i_clk, // core clock
	input wire logic i_scl, // resolved scl level
	input wire logic i_sda, // resolved sda level
	input wire logic [7:0] i_stretch, // scl low hold after ack, cycles
	output logic o_scl_oe, // pull scl low
	output logic o_sda_oe, // pull sda low
	output logic [7:0] o_byte // last byte taken
);
	logic scl_q, sda_q, sel, first; // line history, addressed, address phase
	logic [3:0] cnt; // bit count in byte
	logic [7:0] sh, hold; // shifter, stretch count
	initial begin
		{scl_q, sda_q, sel, first, o_scl_oe, o_sda_oe} = '0;
		{cnt, sh, hold, o_byte} = '0;
	end
	// byte receive, ack and stretch
	always @(posedge i_clk) begin
		scl_q <= i_scl;
		sda_q <= i_sda;
		if (hold != 8'h00) begin // stretch scl low
			hold <= hold - 8'h01;
			if (hold == 8'h01) o_scl_oe <= 1'b0;
		end
		if (scl_q && i_scl && sda_q != i_sda) begin // start or stop
			cnt <= 4'h0;
			first <= !i_sda;
			sel <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (!scl_q && i_scl && cnt < 4'h9) begin // sample msb first
			if (cnt < 4'h8) sh <= {sh[6:0], i_sda};
			cnt <= cnt + 4'h1;
		end else if (scl_q && !i_scl) begin
			if (cnt == 4'h8) begin // drive ack in ninth bit
				o_sda_oe <= first ? (sh[7:1] == ADDR && !sh[0]) : sel;
				if (first) sel <= (sh[7:1] == ADDR);
				first <= 1'b0;
				o_byte <= sh;
			end else if (cnt == 4'h9) begin // release after ack
				o_sda_oe <= 1'b0;
				cnt <= 4'h0;
				hold <= i_stretch;
				o_scl_oe <= (i_stretch != 8'h00);
			end
		end
	end
endmodule : tws_slave_model

// ### dv/tb.sv
// bench top: apb host, wired-and bus, slave partner, table and hand tests
// assumes the controller answers apb with zero wait states
`timescale 1ns/1ns
module tb;
	import tws_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tws_row_t;
	logic clk, rst_n, psel, pen, pwr, pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, rl;
	logic s_scl_oe, s_sda_oe, tb_sda, tb_scl, meas, ps, pd, e;
	logic [7:0] paddr, s_byte, stretch;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] ovf;
	int n_errors, checked, nsta, nsto, ph, oc, s0;
	time t0;
	wire scl = !(scl_oe | s_scl_oe | tb_scl);
	wire sda = !(sda_oe | s_sda_oe | tb_sda);
	tws_row_t rows[8] = '{'{0, REG_CFG, 0, {25'h0, CFG_RST}, 0}, '{0, REG_ADR, 0, {24'h0, ADR_RST, 1'b0}, 0},
		'{1, REG_ADR, 32'ha4, 0, 0}, '{0, REG_ADR, 0, 32'ha4, 0}, '{1, REG_CFG, 32'h7e, 0, 0},
		'{0, REG_CFG, 0, 32'h7e, 0}, '{1, 8'h10, 32'h5, 0, 1}, '{0, 8'h10, 0, 0, 1}};
	tws_ctrl u_tws_ctrl (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_clk_ovf(ovf), .i_scl(scl), .i_sda(sda), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_sda_o(sda_o),
		.o_sda_oe(sda_oe), .o_tmr_reload(rl));
	tws_slave_model u_tws_slave_model (.i_clk(clk), .i_scl(scl), .i_sda(sda), .i_stretch(stretch),
		.o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_byte(s_byte));
	always #25 clk = !clk;
	// overflow sources, every 10 cycles at staggered phases
	always @(posedge clk) begin
		oc <= (oc == 9) ? 0 : oc + 1;
		ovf <= {oc == 1, oc == 3, oc == 5, oc == 9};
	end
	// wire monitor: start, stop and scl phase lengths
	always @(posedge clk) begin
		ps <= scl;
		pd <= sda;
		if (ps && scl && pd && !sda) nsta <= nsta + 1;
		if (ps && scl && !pd && sda) nsto <= nsto + 1;
		ph <= (scl != ps) ? 1 : ph + 1;
		if (meas && scl != ps && ph < int'(MIN_HALF)) begin
			n_errors++;
			$display("[FAIL] %0t scl phase short", $time);
		end
	end
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	// poll control until a status bit is set
	task automatic wbit(input int b);
		int n;
		n = 0;
		do begin
			apb(0, REG_CTL, 0);
			n++;
		end while (r[b] !== 1'b1 && n < 600);
		chk(n < 600, "status bit never set");
	endtask : wbit
	task automatic wstop();
		int n;
		for (n = 0; n < 600 && nsto == s0; n++) @(posedge clk);
		apb(0, REG_CTL, 0);
		chk(nsto != s0 && r[CTL_BUSY] === 1'b0, "no stop");
	endtask : wstop
	// master write: start, address, optional data byte, stop
	task automatic mwrite(input logic [7:0] ab, input logic [7:0] db, input logic ak);
		meas = 1'b1;
		s0 = nsta;
		apb(1, REG_CTL, 32'h1);
		wbit(CTL_SI);
		chk(r[CTL_MST] === 1'b1 && nsta == s0 + 1, "no start");
		apb(1, REG_DAT, {24'h0, ab});
		apb(1, REG_CTL, 32'h8);
		wbit(CTL_SI);
		chk(r[CTL_ACK] === ak, "address ack");
		if (ak) begin
			chk(s_byte === ab, "address byte");
			apb(1, REG_DAT, {24'h0, db});
			apb(1, REG_CTL, 32'h8);
			wbit(CTL_SI);
			chk(s_byte === db && r[CTL_ACK] === 1'b1, "data byte");
		end
		s0 = nsto;
		apb(1, REG_CTL, 32'ha);
		wstop();
		meas = 1'b0;
	endtask : mwrite
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		#3000000;
		n_errors++;
		$display("[FAIL] %0t watchdog", $time);
		tally_and_finish();
	end
	initial begin
		{clk, rst_n, psel, pen, pwr, tb_sda, tb_scl, meas, ps, pd} = '0;
		{paddr, pwdata, stretch, ovf} = '0;
		{n_errors, checked, nsta, nsto, ph, oc} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin // register table and unmapped place
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk((rows[i].w || r === rows[i].x) && e === rows[i].e, "register row");
		end
		apb(1, REG_CFG, 32'h5);
		repeat (3) @(posedge clk);
		chk(rl === 1'b1, "reload with scl high");
		apb(1, REG_CFG, 32'h1);
		repeat (3) @(posedge clk);
		chk(rl === 1'b0 && scl_o === 1'b0 && sda_o === 1'b0, "reload off");
		mwrite(8'ha4, 8'h3c, 1'b1);
		stretch <= 8'd40;
		mwrite(8'ha4, 8'hc3, 1'b1);
		stretch <= 8'd0;
		mwrite(8'h66, 8'h00, 1'b0);
		apb(1, REG_CTL, 32'h1); // arbitration: rival pulls sda low
		wbit(CTL_SI);
		apb(1, REG_DAT, 32'hfe);
		apb(1, REG_CTL, 32'h8);
		tb_sda <= 1'b1;
		wbit(CTL_ARB);
		chk(r[CTL_MST] === 1'b0 && sda_oe === 1'b0 && r[CTL_BUSY] === 1'b1, "arb loss");
		apb(1, REG_CTL, 32'h40);
		apb(0, REG_CTL, 0);
		chk(r[CTL_ARB] === 1'b0, "arb clear");
		tb_scl <= 1'b1; // lower scl under held sda: lines go idle with no stop
		repeat (4) @(posedge clk);
		tb_sda <= 1'b0;
		repeat (4) @(posedge clk);
		tb_scl <= 1'b0;
		@(posedge clk);
		apb(0, REG_CTL, 0);
		chk(r[CTL_BUSY] === 1'b1, "busy without stop");
		t0 = $time;
		s0 = nsta;
		apb(1, REG_CFG, 32'hd);
		apb(1, REG_CTL, 32'h1);
		wbit(CTL_SI);
		chk(nsta == s0 + 1 && ($time - t0) / 50 >= 10 * FREE_TICKS, "free timeout");
		chk(rl === 1'b0, "reload with scl low");
		s0 = nsto;
		apb(1, REG_CTL, 32'ha);
		wstop();
		apb(1, REG_CTL, 32'h1);
		wbit(CTL_SI);
		apb(1, REG_DAT, 32'ha4);
		apb(1, REG_CTL, 32'h8);
		repeat (60) @(posedge clk);
		apb(1, REG_CFG, 32'h0);
		apb(1, REG_CFG, 32'h1);
		repeat (4) @(posedge clk);
		apb(0, REG_CTL, 0);
		chk(scl_oe === 1'b0 && sda_oe === 1'b0 && r[CTL_MST] === 1'b0, "re-enable");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(pready === 1'b0 && scl_oe === 1'b0 && rl === 1'b0, "reset outputs");
		tally_and_finish();
	end
endmodule : tb
